// file: verilog/tsf_capture.v
// transport stream capture into the endpoint two slave fifo, with ahb-lite setup registers
// Function
// R1 - source sends fixed packets, four-byte header first
// R2 - packet start marker only on first byte
// R3 - qualifier only while byte lines valid
// R4 - continuity counter rises per packet identifier
// R5 - interface clock pin input, optionally output
// R6 - sixteen-bit bus, select lines choose fifo
// R7 - sync read advances pointer per clock edge
// R8 - async read advances on strobe release
// R9 - bus driven only under output enable
// R10 - two flags: full, empty or level
// R11 - sync write stores byte per clock edge
// R12 - async write stores on strobe release
// R13 - free-running stream clock keeps toggling
// R14 - free mode: stream clock, qualifier writes
// R15 - select lines held at endpoint two
// R16 - gated mode: gated clock is write strobe
// R17 - config value: external clock, optional inversion
// R18 - polarity setting: write strobe active high
// R19 - endpoint two bulk, four 512 buffers
// R20 - endpoint two eight-bit automatic commit
// R21 - commit each 512 bytes, length high/low
// R22 - gated config: async, strobe release loads
// R23 - eight-bit mode ignores upper bus lines
`timescale 1ns/1ps
`include "tsf_map.vh"
module tsf_capture #(
  parameter DEPTH_LOG2 = 11,
  parameter PROG_LEVEL = 11'h400
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        ifClkIn,
  output wire        ifClkOut,
  output wire        ifClkOe_n,
  input  wire [15:0] fdIn,
  output wire [15:0] fdOut,
  output wire [15:0] fdOe_n,
  input  wire [2:0]  fifoSel,
  input  wire        slaveSel_n,
  input  wire        busOe_n,
  input  wire        readStrobe,
  input  wire        writeStrobe,
  output wire        flagA,
  output wire        flagB,
  output wire        commitPulse
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam [DEPTH_LOG2:0] DEPTH_W = DEPTH;
  localparam [DEPTH_LOG2:0] PROG_W = PROG_LEVEL;

  // pins from the stream source cross into clk
  wire [20:0] pinSync;
  tsf_sync2 #(.W(21)) uSync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     ({ifClkIn, writeStrobe, readStrobe, busOe_n, slaveSel_n, fdIn}),
    .dout    (pinSync)
  );
  wire        ifClkS   = pinSync[20];
  wire        wrPinS   = pinSync[19];
  wire        rdPinS   = pinSync[18];
  wire        oeS_n    = pinSync[17];
  wire        csS_n    = pinSync[16];
  wire [15:0] busS     = pinSync[15:0];
  // select lines are hardwired, so static and used unsynchronised
  wire        selEp2   = (fifoSel == `TSF_SEL_EP2); // R15 R6

  // setup registers
  reg [7:0] ifCfg_q;
  reg [7:0] polar_q;
  reg [7:0] epCfg_q;
  reg [7:0] epFifo_q;
  reg [7:0] lenH_q;
  reg [7:0] lenL_q;
  reg [7:0] flagCfg_q;
  reg [7:0] ctrl_q;

  wire asyncMode = ifCfg_q[`TSF_IFCFG_ASYNCB];                      // R16 R22
  wire clkInv    = ifCfg_q[`TSF_IFCFG_INVB];                        // R17
  wire clkDrive  = ifCfg_q[`TSF_IFCFG_CLKOUTB] & ~asyncMode;        // R5
  wire wrActHi   = polar_q[`TSF_POLAR_WRB];                         // R18
  wire automatic_commit_in    = epFifo_q[`TSF_EPFIFO_AUTOB];                     // R20
  wire wide      = epFifo_q[`TSF_EPFIFO_WIDEB];
  wire [10:0] commitLen = {lenH_q[2:0], lenL_q};                    // R21

  // interface clock: sampled input by default, or driven out from a divider
  reg ifClkGen_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ifClkGen_q <= 1'b0;
    end else begin
      ifClkGen_q <= ~ifClkGen_q;
    end
  end
  assign ifClkOut  = ifClkGen_q;
  assign ifClkOe_n = ~clkDrive;                                     // R5

  reg ifClkPrev_q;
  reg wrPrev_q;
  reg rdPrev_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ifClkPrev_q <= 1'b0;
      wrPrev_q    <= 1'b0;
      rdPrev_q    <= 1'b0;
    end else begin
      ifClkPrev_q <= clkDrive ? ifClkGen_q : (ifClkS ^ clkInv);
      wrPrev_q    <= wrPinS;
      rdPrev_q    <= rdPinS;
    end
  end
  wire ifClkNow  = clkDrive ? ifClkGen_q : (ifClkS ^ clkInv);       // R17
  wire ifRise    = ifClkNow & ~ifClkPrev_q;
  wire wrAct     = wrActHi ? wrPinS : ~wrPinS;                      // R18
  wire wrActPrev = wrActHi ? wrPrev_q : ~wrPrev_q;
  wire rdAct     = ~rdPinS;
  wire rdActPrev = ~rdPrev_q;
  wire selOk     = ~csS_n & selEp2;

  wire wrEvt = selOk & (asyncMode ? (wrActPrev & ~wrAct)            // R12 R16 R22
                                  : (ifRise & wrAct));              // R11 R14
  wire rdEvt = selOk & (asyncMode ? (rdActPrev & ~rdAct)            // R8
                                  : (ifRise & rdAct));              // R7

  // fifo storage
  reg [15:0]         mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wrPtr_q;
  reg [DEPTH_LOG2:0] rdPtr_q;
  reg [DEPTH_LOG2:0] commitPtr_q;
  wire [DEPTH_LOG2:0] level = wrPtr_q - rdPtr_q;
  wire full  = (level == DEPTH_W);
  wire empty = (level == {(DEPTH_LOG2+1){1'b0}});
  wire doWr  = wrEvt & ~full;
  wire doRd  = rdEvt & ~empty;
  // eight-bit mode keeps only the low byte lines
  wire [15:0] wrWord = wide ? busS : {8'h00, busS[7:0]};            // R23

  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_q[DEPTH_LOG2-1:0]] <= wrWord;                       // R11 R12
    end
  end

  reg [10:0] fillCnt_q;
  reg        commit_q;
  reg [15:0] pktCnt_q;
  reg [7:0]  pktByte_q;
  reg        overflow_q;
  reg [15:0] rdData_q;
  wire clrOvf  = ctrl_q[0];
  wire pktDone = doWr & (pktByte_q == `TSF_PKT_LEN - 8'h01);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q     <= {(DEPTH_LOG2+1){1'b0}};
      rdPtr_q     <= {(DEPTH_LOG2+1){1'b0}};
      commitPtr_q <= {(DEPTH_LOG2+1){1'b0}};
      fillCnt_q   <= 11'h000;
      commit_q    <= 1'b0;
      pktCnt_q    <= 16'h0000;
      pktByte_q   <= 8'h00;
      overflow_q  <= 1'b0;
      rdData_q    <= 16'h0000;
    end else begin
      commit_q <= 1'b0;
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;                                  // R11 R12
        pktByte_q <= pktDone ? 8'h00 : pktByte_q + 8'h01;
        // with automatic commit on, commit every commitLen writes to the host side
        if (automatic_commit_in && fillCnt_q == commitLen - 11'h001) begin       // R21 R20
          fillCnt_q   <= 11'h000;
          commit_q    <= 1'b1;
          commitPtr_q <= wrPtr_q + 1'b1;
        end else begin
          fillCnt_q <= fillCnt_q + 11'h001;
        end
      end
      if (pktDone) begin
        pktCnt_q <= pktCnt_q + 16'h0001;
      end
      if (doRd) begin
        rdPtr_q  <= rdPtr_q + 1'b1;                                 // R7 R8
        rdData_q <= mem[rdPtr_q[DEPTH_LOG2-1:0]];
      end
      // set wins over software clear
      if (wrEvt && full) begin
        overflow_q <= 1'b1;
      end else if (clrOvf) begin
        overflow_q <= 1'b0;
      end
    end
  end
  assign commitPulse = commit_q;

  // bus drive back toward the pins
  assign fdOut  = rdData_q;
  assign fdOe_n = {16{~(~oeS_n & selOk)}};                          // R9

  // flag selection; flags are active low like the select, output enable and read strobe pins
  function flagOf;
    input [1:0] sel;
    input       f;
    input       e;
    input       p;
    begin
      case (sel)
        `TSF_FLAG_FULL:  flagOf = ~f;
        `TSF_FLAG_EMPTY: flagOf = ~e;
        `TSF_FLAG_PROG:  flagOf = ~p;
        default:         flagOf = 1'b1;
      endcase
    end
  endfunction
  wire progHit = (level >= PROG_W);
  reg flagA_q;
  reg flagB_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flagA_q <= 1'b1;
      flagB_q <= 1'b1;
    end else begin
      flagA_q <= flagOf(flagCfg_q[1:0], full, empty, progHit);      // R10
      flagB_q <= flagOf(flagCfg_q[5:4], full, empty, progHit);      // R10
    end
  end
  assign flagA = flagA_q;
  assign flagB = flagB_q;

  // ahb-lite slave, zero wait states
  reg        phWr_q;
  reg        phRd_q;
  reg [11:0] phAddr_q;
  wire take = hsel & hready & htrans[`TSF_HTRANS_NSEQ];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phWr_q   <= 1'b0;
      phRd_q   <= 1'b0;
      phAddr_q <= 12'h000;
    end else begin
      phWr_q   <= take & hwrite;
      phRd_q   <= take & ~hwrite;
      phAddr_q <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = `TSF_HRESP_OKAY;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ifCfg_q   <= `TSF_RST_IFCFG;                                  // R17
      polar_q   <= `TSF_RST_POLAR;                                  // R18
      epCfg_q   <= `TSF_RST_EPCFG;                                  // R19
      epFifo_q  <= `TSF_RST_EPFIFO;                                 // R20
      lenH_q    <= `TSF_RST_LENH;                                   // R21
      lenL_q    <= `TSF_RST_LENL;                                   // R21
      flagCfg_q <= `TSF_RST_FLAGCFG;
      ctrl_q    <= `TSF_RST_CTRL;
    end else begin
      ctrl_q <= 8'h00;
      if (phWr_q) begin
        case (phAddr_q)
          `TSF_OFF_IFCFG:   ifCfg_q   <= hwdata[7:0];
          `TSF_OFF_POLAR:   polar_q   <= hwdata[7:0];
          `TSF_OFF_EPCFG:   epCfg_q   <= hwdata[7:0];
          `TSF_OFF_EPFIFO:  epFifo_q  <= hwdata[7:0];
          `TSF_OFF_LENH:    lenH_q    <= hwdata[7:0];
          `TSF_OFF_LENL:    lenL_q    <= hwdata[7:0];
          `TSF_OFF_FLAGCFG: flagCfg_q <= hwdata[7:0];
          `TSF_OFF_CTRL:    ctrl_q    <= hwdata[7:0];
          default:          ctrl_q    <= 8'h00;
        endcase
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      case (haddr)
        `TSF_OFF_IFCFG:   hrdata <= {24'h000000, ifCfg_q};
        `TSF_OFF_POLAR:   hrdata <= {24'h000000, polar_q};
        `TSF_OFF_EPCFG:   hrdata <= {24'h000000, epCfg_q};
        `TSF_OFF_EPFIFO:  hrdata <= {24'h000000, epFifo_q};
        `TSF_OFF_LENH:    hrdata <= {24'h000000, lenH_q};
        `TSF_OFF_LENL:    hrdata <= {24'h000000, lenL_q};
        `TSF_OFF_FLAGCFG: hrdata <= {24'h000000, flagCfg_q};
        `TSF_OFF_STATUS:  hrdata <= {16'h0000, 4'h0, level[DEPTH_LOG2:0] > 12'h000 ? 1'b1 : 1'b0,
                                     overflow_q, full, empty, commitPtr_q[7:0]};
        `TSF_OFF_DATA:    hrdata <= {16'h0000, rdData_q};
        `TSF_OFF_PKTCNT:  hrdata <= {16'h0000, pktCnt_q};
        default:          hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule // tsf_capture

// file: verilog/tsf_map.vh
// register map, field layouts and reset values of the stream capture port
`ifndef TSF_MAP_VH
`define TSF_MAP_VH
`define TSF_OFF_IFCFG     12'h000
`define TSF_OFF_POLAR     12'h004
`define TSF_OFF_EPCFG     12'h008
`define TSF_OFF_EPFIFO    12'h00c
`define TSF_OFF_LENH      12'h010
`define TSF_OFF_LENL      12'h014
`define TSF_OFF_FLAGCFG   12'h018
`define TSF_OFF_STATUS    12'h01c
`define TSF_OFF_DATA      12'h020
`define TSF_OFF_PKTCNT    12'h024
`define TSF_OFF_CTRL      12'h028
`define TSF_RST_IFCFG     8'h03
`define TSF_RST_POLAR     8'h04
`define TSF_RST_EPCFG     8'he0
`define TSF_RST_EPFIFO    8'h08
`define TSF_RST_LENH      8'h02
`define TSF_RST_LENL      8'h00
`define TSF_RST_FLAGCFG   8'h21
`define TSF_RST_CTRL      8'h00
`define TSF_IFCFG_SYNC    8'h03
`define TSF_IFCFG_INV     8'h13
`define TSF_IFCFG_ASYNC   8'hcb
`define TSF_IFCFG_ASYNCB  3
`define TSF_IFCFG_INVB    4
`define TSF_IFCFG_CLKOUTB 5
`define TSF_POLAR_WRB     2
`define TSF_EPFIFO_AUTOB  3
`define TSF_EPFIFO_WIDEB  0
`define TSF_FLAG_FULL     2'h0
`define TSF_FLAG_EMPTY    2'h1
`define TSF_FLAG_PROG     2'h2
`define TSF_SEL_EP2       3'h0
`define TSF_HTRANS_NSEQ   1
`define TSF_HRESP_OKAY    1'h0
`define TSF_PKT_LEN       8'hbc
`endif

// file: verilog/tsf_sync2.v
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module tsf_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // tsf_sync2

// file: verif/tsf_capture_asserts.sv
// checker on the stream capture port outputs
`timescale 1ns/1ps
module tsf_capture_asserts (
  input logic        clk,
  input logic        reset_n,
  input logic        hsel,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata,
  input logic        slaveSel_n,
  input logic        busOe_n,
  input logic [15:0] fdOe_n,
  input logic        ifClkOe_n,
  input logic        flagA,
  input logic        flagB,
  input logic        commitPulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pins cross two flops, so allow four cycles
  sequence oeOff; busOe_n [*4]; endsequence
  sequence desel; slaveSel_n [*4]; endsequence
  sequence quiet; !commitPulse [*8]; endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
  a_oe_off: assert property (oeOff |-> &fdOe_n) else $error("bus driven, no enable");
  a_oe_desel: assert property (desel |-> &fdOe_n) else $error("bus driven, deselected");
  a_oe_whole: assert property (&fdOe_n || fdOe_n == 16'h0) else $error("bus enable split");
  a_commit_once: assert property (commitPulse |=> quiet) else $error("commit pulse too long");
  a_rdata_hold: assert property (!(hsel && htrans == 2'h2 && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_clk_input: assert property ($rose(reset_n) |-> ifClkOe_n) else $error("clock pin driven");
  a_flags_idle: assert property ($rose(reset_n) |-> flagA && flagB) else $error("flag after reset");
endmodule // tsf_capture_asserts
bind tsf_capture tsf_capture_asserts u_chk (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .slaveSel_n(slaveSel_n),
  .busOe_n(busOe_n), .fdOe_n(fdOe_n), .ifClkOe_n(ifClkOe_n), .flagA(flagA),
  .flagB(flagB), .commitPulse(commitPulse)
);

// file: verif/tsf_ts_source.sv
// transport stream source model on the capture port pins
`timescale 1ns/1ps
module tsf_ts_source (
  input  wire         gated,
  output wire         sClk,
  output logic        sValid,
  output logic        sStart,
  output logic [15:0] fd
);
  logic       fClk = 0;
  logic       gClk = 0;
  logic [3:0] cc = 0;
  logic [7:0] b;
  int         sent[$];
  initial forever #40 fClk = ~fClk;
  assign sClk = gated ? gClk : fClk;
  initial begin
    sValid = 0;
    sStart = 0;
    fd = 16'h5a5a;
  end
  task send(input int n);
    for (int p = 0; p < n; p++) begin
      for (int i = 0; i < 188; i++) begin
        b = i == 0 ? 8'h47 : i == 1 ? 8'h00 : i == 2 ? 8'h21 : i == 3 ? {4'h1, cc} : 8'($urandom);
        if (gated) #40;
        else @(negedge fClk);
        fd = {8'($urandom), b};
        sValid = !gated;
        sStart = i == 0;
        sent.push_back(b);
        if (gated) begin
          #40 gClk = 1;
          #40 gClk = 0;
        end
      end
      cc++;
    end
    if (gated) #40;
    else @(negedge fClk);
    sValid = 0;
    sStart = 0;
    // released lines must not keep the last byte
    fd = ~fd;
  endtask
endmodule // tsf_ts_source

// file: verif/tb_top.sv
// testbench: stream source into the capture port against a byte queue
`timescale 1ns/1ps
`include "tsf_map.vh"
module tb_top;
  localparam int DEPTH = 2048;
  logic        clk = 0, reset_n = 0, hsel = 0, hwrite = 0, gated = 0;
  logic        slaveSel_n = 1, busOe_n = 1, readStrobe = 1;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] hwdata = 0, r;
  logic [7:0]  rv[6] = '{8'h03, 8'h04, 8'he0, 8'h08, 8'h02, 8'h00};
  wire         hreadyout, hresp, ifClkOut, ifClkOe_n, flagA, flagB, commitPulse, sClk, sValid, sStart;
  wire  [31:0] hrdata;
  wire  [15:0] fd, fdOut, fdOe_n;
  wire  [15:0] fdBus = (fd & fdOe_n) | (fdOut & ~fdOe_n);
  wire         interface_clock_pin = !ifClkOe_n ? ifClkOut : (gated ? 1'b0 : sClk);
  int          mismatches = 0, comparisons = 0, commits = 0, exp[$];
  tsf_capture dut (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ifClkIn(interface_clock_pin), .ifClkOut(ifClkOut), .ifClkOe_n(ifClkOe_n), .fdIn(fdBus),
    .fdOut(fdOut), .fdOe_n(fdOe_n), .fifoSel(3'h0), .slaveSel_n(slaveSel_n), .busOe_n(busOe_n),
    .readStrobe(readStrobe), .writeStrobe(gated ? sClk : sValid), .flagA(flagA), .flagB(flagB),
    .commitPulse(commitPulse)
  );
  tsf_ts_source m (.gated(gated), .sClk(sClk), .sValid(sValid), .sStart(sStart), .fd(fd));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (commitPulse === 1'b1) commits++;
  task chk(string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // model keeps only what fits, the rest overflows
  task feed;
    foreach (m.sent[i]) if (exp.size() < DEPTH) exp.push_back(m.sent[i]);
    m.sent.delete();
    #100;
  endtask
  task drain(input int n);
    int e;
    busOe_n <= 0;
    for (int i = 0; i < n; i++) begin
      if (!gated) @(negedge sClk);
      @(posedge clk) readStrobe <= 0;
      if (gated) #80;
      else @(negedge sClk);
      @(posedge clk) readStrobe <= 1;
      #60;
      e = exp.pop_front();
      ahb(0, `TSF_OFF_DATA, 0);
      chk("data", r, 32'(e));
      chk("bus", {16'h0, fdOut}, 32'(e));
    end
    busOe_n <= 1;
    ahb(0, `TSF_OFF_STATUS, 0);
    chk("empty", r[8], 1);
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1500000;
    mismatches++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'hb05b));
    repeat (6) @(posedge clk);
    reset_n <= 1;
    repeat (10) @(posedge clk);
    chk("oe", {16'h0, fdOe_n}, 32'hffff);
    chk("empty flag", flagA, 0);
    for (int i = 0; i < 6; i++) begin
      ahb(0, 12'(i * 4), 0);
      chk("reset value", r, {24'h0, rv[i]});
    end
    ahb(0, 12'h040, 0);
    chk("unmapped", r, 0);
    slaveSel_n <= 0;
    m.send(11);
    feed();
    ahb(0, `TSF_OFF_STATUS, 0);
    chk("full", r[10:9], 2'h3);
    chk("commits", commits, DEPTH / 512);
    ahb(1, `TSF_OFF_CTRL, 1);
    ahb(0, `TSF_OFF_STATUS, 0);
    chk("overflow", r[10], 0);
    drain(DEPTH);
    gated <= 1;
    ahb(1, `TSF_OFF_IFCFG, `TSF_IFCFG_ASYNC);
    m.send(1);
    feed();
    drain(188);
    end_of_test;
  end
endmodule // tb_top
